// >>> design/ocp_clock_control.sv
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ocp_clock_control #(
    parameter int MS_CYCLES = ocp_pkg::CYCLES_PER_MS,
    parameter int STARTUP_CYCLES = ocp_pkg::STARTUP_CYCLES,
    parameter int TIMER_W = 20
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [ocp_pkg::ADDR_W-1:0] regAddr,
    input wire logic [ocp_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [ocp_pkg::DATA_W-1:0] regRdata,
    input wire logic periphRequest,
    input wire logic standbySleep,
    input wire logic loopLockRaw,
    output logic oscRun,
    output logic crystalDrive,
    output logic oscInExtClock,
    output logic oscOutPadFree,
    output ocp_pkg::ocp_loop_cfg_t loopCfg,
    output logic loopAnalogEnable,
    output logic loopOutputOpen,
    output logic lockTimeout
);

    generate
        if (MS_CYCLES < 1 || STARTUP_CYCLES < 1 ||
            STARTUP_CYCLES >= (2 ** TIMER_W) ||
            ocp_pkg::LTO_LAST_MS * MS_CYCLES >= (2 ** TIMER_W))
        begin : gCheck
            $error("ocp_clock_control: counts do not fit the timer width");
        end
    endgenerate

    // Limit in cycles for a time-out code; reserved and off codes give zero
    function automatic logic [TIMER_W-1:0] timeoutLimit(input logic [2:0] code);
        int ms;
        ms = 0;
        if (code >= ocp_pkg::LTO_FIRST)
        begin
            ms = ocp_pkg::LTO_BASE_MS + int'(code - ocp_pkg::LTO_FIRST);
        end
        return TIMER_W'(ms * MS_CYCLES);
    endfunction

    // Reset release through two flip-flops
    logic rstMeta;
    logic rstnSync;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rstMeta <= 1'b0;
            rstnSync <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstnSync <= rstMeta;
        end
    end

    // Lock signal from the analog loop is asynchronous
    logic lockMeta;
    logic lockSync;

    always_ff @(posedge clock or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            lockMeta <= 1'b0;
            lockSync <= 1'b0;
        end
        else
        begin
            lockMeta <= loopLockRaw;
            lockSync <= lockMeta;
        end
    end

    // Register file
    ocp_pkg::ocp_osc_ctrl_t oscCtrl;
    ocp_pkg::ocp_osc_ctrl_t next_oscCtrl;
    ocp_pkg::ocp_loop_ctrl_t loopCtrl;
    ocp_pkg::ocp_loop_ctrl_t next_loopCtrl;
    logic loopEnable;
    logic next_loopEnable;
    logic timeoutFlag;
    logic next_timeoutFlag;
    logic [ocp_pkg::DATA_W-1:0] next_regRdata;
    logic timeoutEvent;
    logic startupDone;
    logic [ocp_pkg::DATA_W-1:0] statusWord;

    always_comb
    begin
        next_oscCtrl = oscCtrl;
        next_loopCtrl = loopCtrl;
        next_loopEnable = loopEnable;
        next_timeoutFlag = timeoutFlag;
        if (regWrite && regAddr == ocp_pkg::OSC_CTRL_ADDR)
        begin
            next_oscCtrl = regWdata & ocp_pkg::OSC_CTRL_MASK;
        end
        if (regWrite && regAddr == ocp_pkg::LOOP_CTRL_ADDR)
        begin
            next_loopCtrl = regWdata & ocp_pkg::LOOP_CTRL_MASK;
        end
        if (regWrite && regAddr == ocp_pkg::LOOP_EN_ADDR)
        begin
            next_loopEnable = regWdata[ocp_pkg::LOOP_EN_BIT];
        end
        if (regWrite && regAddr == ocp_pkg::STATUS_ADDR &&
            regWdata[ocp_pkg::ST_TIMEOUT_BIT])
        begin
            next_timeoutFlag = 1'b0;
        end
        // A time-out in the clearing cycle still sets the flag
        if (timeoutEvent)
        begin
            next_timeoutFlag = 1'b1;
        end
    end

    always_comb
    begin
        statusWord = '0;
        statusWord[ocp_pkg::ST_OSC_RUN_BIT] = oscRun;
        statusWord[ocp_pkg::ST_LOCK_BIT] = lockSync;
        statusWord[ocp_pkg::ST_STARTUP_BIT] = startupDone;
        statusWord[ocp_pkg::ST_OPEN_BIT] = loopOutputOpen;
        statusWord[ocp_pkg::ST_TIMEOUT_BIT] = timeoutFlag;
        next_regRdata = '0;
        if (regRead)
        begin
            unique case (regAddr)
                ocp_pkg::OSC_CTRL_ADDR: next_regRdata = oscCtrl;
                ocp_pkg::LOOP_CTRL_ADDR: next_regRdata = loopCtrl;
                ocp_pkg::LOOP_EN_ADDR: next_regRdata[ocp_pkg::LOOP_EN_BIT] = loopEnable;
                ocp_pkg::STATUS_ADDR: next_regRdata = statusWord;
                default: next_regRdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            oscCtrl <= ocp_pkg::OSC_CTRL_RESET;
            loopCtrl <= ocp_pkg::LOOP_CTRL_RESET;
            loopEnable <= ocp_pkg::LOOP_EN_RESET;
            timeoutFlag <= 1'b0;
            regRdata <= '0;
        end
        else
        begin
            oscCtrl <= next_oscCtrl;
            loopCtrl <= next_loopCtrl;
            loopEnable <= next_loopEnable;
            timeoutFlag <= next_timeoutFlag;
            regRdata <= next_regRdata;
        end
    end

    // Loop sequencing: startup, lock wait, time-out
    ocp_pkg::ocp_loop_state_t loopState;
    ocp_pkg::ocp_loop_state_t next_loopState;
    logic [TIMER_W-1:0] startupCount;
    logic [TIMER_W-1:0] next_startupCount;
    logic [TIMER_W-1:0] lockCount;
    logic [TIMER_W-1:0] next_lockCount;
    logic timedOut;
    logic next_timedOut;
    logic [TIMER_W-1:0] lockLimit;

    always_comb
    begin
        next_loopState = loopState;
        next_startupCount = startupCount;
        next_lockCount = lockCount;
        next_timedOut = timedOut;
        timeoutEvent = 1'b0;
        lockLimit = timeoutLimit(loopCtrl.lockTimeoutSel);
        unique case (loopState)
            ocp_pkg::LOOP_OFF:
            begin
                next_startupCount = '0;
                next_lockCount = '0;
                next_timedOut = 1'b0;
                if (loopEnable)
                begin
                    next_loopState = ocp_pkg::LOOP_STARTUP;
                end
            end
            ocp_pkg::LOOP_STARTUP:
            begin
                next_startupCount = startupCount + 1'b1;
                if (startupCount == TIMER_W'(STARTUP_CYCLES - 1))
                begin
                    next_loopState = ocp_pkg::LOOP_LOCKING;
                end
            end
            ocp_pkg::LOOP_LOCKING:
            begin
                if (lockSync)
                begin
                    next_loopState = ocp_pkg::LOOP_RUN;
                end
            end
            ocp_pkg::LOOP_RUN:
            begin
            end
        endcase
        // Time-out measured from enable until first lock
        if (loopState != ocp_pkg::LOOP_OFF && loopState != ocp_pkg::LOOP_RUN &&
            !lockSync && !timedOut)
        begin
            next_lockCount = lockCount + 1'b1;
            if (lockLimit != '0 && lockCount == lockLimit - 1'b1)
            begin
                timeoutEvent = 1'b1;
                next_timedOut = 1'b1;
            end
        end
        if (!loopEnable)
        begin
            next_loopState = ocp_pkg::LOOP_OFF;
        end
    end

    always_ff @(posedge clock or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            loopState <= ocp_pkg::LOOP_OFF;
            startupCount <= '0;
            lockCount <= '0;
            timedOut <= 1'b0;
        end
        else
        begin
            loopState <= next_loopState;
            startupCount <= next_startupCount;
            lockCount <= next_lockCount;
            timedOut <= next_timedOut;
        end
    end

    assign startupDone = loopState == ocp_pkg::LOOP_LOCKING ||
        loopState == ocp_pkg::LOOP_RUN;

    // Registered outputs
    logic next_oscRun;
    logic next_crystalDrive;
    logic next_oscInExtClock;
    logic next_oscOutPadFree;
    ocp_pkg::ocp_loop_cfg_t next_loopCfg;
    logic next_loopAnalogEnable;
    logic next_loopOutputOpen;
    logic demandRun;

    always_comb
    begin
        demandRun = oscCtrl.runOnRequest ? periphRequest : 1'b1;
        next_oscRun = oscCtrl.enable & demandRun;
        if (standbySleep)
        begin
            next_oscRun = oscCtrl.enable & oscCtrl.keepRunningInStandby & demandRun;
        end
        next_crystalDrive = oscCtrl.crystalSelect;
        next_oscInExtClock = !oscCtrl.crystalSelect;
        next_oscOutPadFree = !oscCtrl.crystalSelect;
        next_loopCfg.refSelect = loopCtrl.loopRefSelect;
        if (loopCtrl.loopRefSelect != ocp_pkg::REF_FAST_OSC &&
            loopCtrl.loopRefSelect != ocp_pkg::REF_GENERIC)
        begin
            next_loopCfg.refSelect = ocp_pkg::REF_SLOW_XTAL;
        end
        next_loopCfg.phaseDetectBypass = loopCtrl.lowPowerPhaseDetect;
        next_loopCfg.lowBandwidthFilter = loopCtrl.filterSel == ocp_pkg::FILT_LOW_BW;
        next_loopAnalogEnable = loopEnable;
        next_loopOutputOpen = 1'b0;
        if (loopState != ocp_pkg::LOOP_OFF && loopEnable)
        begin
            if (loopCtrl.lockIgnore)
            begin
                next_loopOutputOpen = 1'b1;
            end
            else
            begin
                next_loopOutputOpen = startupDone & (loopCtrl.fastWake | lockSync);
            end
        end
    end

    always_ff @(posedge clock or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            oscRun <= 1'b0;
            crystalDrive <= 1'b0;
            oscInExtClock <= 1'b1;
            oscOutPadFree <= 1'b1;
            loopCfg <= '0;
            loopAnalogEnable <= 1'b0;
            loopOutputOpen <= 1'b0;
        end
        else
        begin
            oscRun <= next_oscRun;
            crystalDrive <= next_crystalDrive;
            oscInExtClock <= next_oscInExtClock;
            oscOutPadFree <= next_oscOutPadFree;
            loopCfg <= next_loopCfg;
            loopAnalogEnable <= next_loopAnalogEnable;
            loopOutputOpen <= next_loopOutputOpen;
        end
    end

    assign lockTimeout = timeoutFlag;

endmodule
`default_nettype wire

// >>> design/ocp_pkg.sv
package ocp_pkg;

    localparam int CLOCK_HZ = 10_000_000;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OSC_CTRL_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] LOOP_CTRL_ADDR = 4'h4;
    localparam logic [ADDR_W-1:0] LOOP_EN_ADDR = 4'h8;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'hC;

    // Writable bits and reset values
    localparam logic [DATA_W-1:0] OSC_CTRL_MASK = 16'h00C6;
    localparam logic [DATA_W-1:0] LOOP_CTRL_MASK = 16'h173F;
    localparam logic [DATA_W-1:0] OSC_CTRL_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] LOOP_CTRL_RESET = 16'h0000;
    localparam logic LOOP_EN_RESET = 1'b0;
    localparam int LOOP_EN_BIT = 1;

    // Status bit positions
    localparam int ST_OSC_RUN_BIT = 0;
    localparam int ST_LOCK_BIT = 1;
    localparam int ST_STARTUP_BIT = 2;
    localparam int ST_OPEN_BIT = 3;
    localparam int ST_TIMEOUT_BIT = 4;

    // Lock time-out codes
    localparam logic [2:0] LTO_OFF = 3'h0;
    localparam logic [2:0] LTO_FIRST = 3'h4;
    localparam int LTO_BASE_MS = 8;
    localparam int LTO_LAST_MS = 11;

    // Reference and filter select codes
    localparam logic [1:0] REF_SLOW_XTAL = 2'h0;
    localparam logic [1:0] REF_FAST_OSC = 2'h1;
    localparam logic [1:0] REF_GENERIC = 2'h2;
    localparam logic [1:0] FILT_LOW_BW = 2'h1;

    // Timing
    localparam int MS_PER_S = 1000;
    localparam int US_PER_S = 1_000_000;
    localparam int CYCLES_PER_MS = CLOCK_HZ / MS_PER_S;
    localparam int STARTUP_US = 100;
    localparam int STARTUP_CYCLES = (STARTUP_US * (CLOCK_HZ / MS_PER_S) + MS_PER_S - 1) / MS_PER_S;

    typedef struct packed {
        logic [7:0] rsvHigh;
        logic runOnRequest;
        logic keepRunningInStandby;
        logic [2:0] rsvMid;
        logic crystalSelect;
        logic enable;
        logic rsvLow;
    } ocp_osc_ctrl_t;

    typedef struct packed {
        logic [2:0] rsvHigh;
        logic lockIgnore;
        logic rsvMid;
        logic [2:0] lockTimeoutSel;
        logic [1:0] rsvLow;
        logic [1:0] loopRefSelect;
        logic fastWake;
        logic lowPowerPhaseDetect;
        logic [1:0] filterSel;
    } ocp_loop_ctrl_t;

    typedef struct packed {
        logic [1:0] refSelect;
        logic phaseDetectBypass;
        logic lowBandwidthFilter;
    } ocp_loop_cfg_t;

    typedef enum logic [1:0] {
        LOOP_OFF,
        LOOP_STARTUP,
        LOOP_LOCKING,
        LOOP_RUN
    } ocp_loop_state_t;

endpackage

// >>> verification/ocp_clock_control_sva.sv
`timescale 1ns/1ns
`default_nettype none
module ocp_clock_control_sva #(
    parameter int MS_CYCLES = 10,
    parameter int STARTUP_CYCLES = 4
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [ocp_pkg::ADDR_W-1:0] regAddr,
    input wire logic [ocp_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic periphRequest,
    input wire logic standbySleep,
    input wire logic loopLockRaw,
    input wire logic oscRun,
    input wire logic crystalDrive,
    input wire logic oscInExtClock,
    input wire logic oscOutPadFree,
    input wire ocp_pkg::ocp_loop_cfg_t loopCfg,
    input wire logic loopOutputOpen,
    input wire logic lockTimeout
);
    // Shadows of the control registers, rebuilt from the write port
    logic [15:0] osc;
    logic [15:0] lc;
    logic en;
    int cnt;
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            osc <= 16'h0000;
            lc <= 16'h0000;
            en <= 1'b0;
            cnt <= 0;
        end
        else
        begin
            if (regWrite && regAddr == ocp_pkg::OSC_CTRL_ADDR)
                osc <= regWdata;
            if (regWrite && regAddr == ocp_pkg::LOOP_CTRL_ADDR)
                lc <= regWdata;
            if (regWrite && regAddr == ocp_pkg::LOOP_EN_ADDR)
                en <= regWdata[1];
            cnt <= en ? cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    AST_OSC_OFF: assert property ($past(!osc[1]) |-> !oscRun)
        else $error("oscillator runs while disabled");
    AST_OSC_ALWAYS: assert property ($past(osc[1] && !osc[7] && !standbySleep) |-> oscRun)
        else $error("oscillator stopped in continuous mode");
    AST_OSC_REQ: assert property ($past(osc[1] && osc[7] && !standbySleep)
        |-> oscRun == $past(periphRequest))
        else $error("oscillator does not follow requests");
    AST_STBY_STOP: assert property ($past(standbySleep && !osc[6]) |-> !oscRun)
        else $error("oscillator runs in standby");
    AST_STBY_KEEP: assert property ($past(standbySleep && osc[6] && osc[1])
        |-> oscRun == $past(!osc[7] || periphRequest))
        else $error("standby run mode wrong");
    AST_PADS: assert property (crystalDrive == $past(osc[2]) && oscInExtClock != crystalDrive
        && oscOutPadFree != crystalDrive)
        else $error("pad connection wrong");
    AST_CFG: assert property (loopCfg == $past({lc[5:4] == 2'h3 ? 2'h0 : lc[5:4], lc[2],
        lc[1:0] == 2'h1}))
        else $error("loop configuration wrong");
    AST_GATE: assert property ((en && !lc[12] && !lc[3] && !loopLockRaw)[*5]
        |-> !loopOutputOpen)
        else $error("output open without lock");
    AST_WAIT: assert property (en && !lc[12] && cnt < STARTUP_CYCLES |-> !loopOutputOpen)
        else $error("output open before startup");
    AST_FAST: assert property (en && lc[3] && cnt >= STARTUP_CYCLES + 4 |-> loopOutputOpen)
        else $error("fast wake output still gated");
    AST_TO_TIME: assert property ($rose(lockTimeout) |-> lc[10] && cnt >= (lc[9:8] + 8) * MS_CYCLES
        && cnt <= (lc[9:8] + 8) * MS_CYCLES + 4)
        else $error("time-out at wrong moment");
    cover property ($rose(lockTimeout));
    cover property ($rose(loopOutputOpen));
    cover property (standbySleep && oscRun);
endmodule
bind ocp_clock_control ocp_clock_control_sva #(.MS_CYCLES(MS_CYCLES),
    .STARTUP_CYCLES(STARTUP_CYCLES)) sva (.clock, .rstn, .regAddr, .regWdata, .regWrite,
    .periphRequest, .standbySleep, .loopLockRaw, .oscRun, .crystalDrive, .oscInExtClock,
    .oscOutPadFree, .loopCfg, .loopOutputOpen, .lockTimeout);
`default_nettype wire

// >>> verification/ocp_clock_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ocp_clock_control_bench;
    localparam int MS = 10;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic periphRequest = 1'b0;
    logic standbySleep = 1'b0;
    logic loopLockRaw = 1'b0;
    logic [15:0] regRdata;
    logic oscRun, crystalDrive, oscInExtClock, oscOutPadFree;
    logic loopAnalogEnable, loopOutputOpen, lockTimeout;
    ocp_pkg::ocp_loop_cfg_t loopCfg;
    int fails = 0;
    int comparisons = 0;
    int cyc = 0;
    int seed = 32'hd735;
    int n;
    logic [15:0] d;
    ocp_clock_control #(.MS_CYCLES(MS), .STARTUP_CYCLES(4)) dut (.clock, .rstn, .regAddr,
        .regWdata, .regWrite, .regRead, .regRdata, .periphRequest, .standbySleep, .loopLockRaw,
        .oscRun, .crystalDrive, .oscInExtClock, .oscOutPadFree, .loopCfg, .loopAnalogEnable,
        .loopOutputOpen, .lockTimeout);
    initial
    begin
        forever #50 clock = ~clock;
    end
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clock);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe edge
    task rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        chk("read data", regRdata & m, exp);
    endtask
    task lp(input logic [15:0] ctrl, input logic lock, input int waitCycles, input logic exp);
        wr(4'h4, ctrl);
        loopLockRaw <= lock;
        wr(4'h8, 16'h0002);
        repeat (waitCycles) @(posedge clock);
        #1;
        chk("output open", loopOutputOpen, exp);
        chk("analog enable", loopAnalogEnable, 1'b1);
        rd(4'hC, {12'h000, exp, 3'h0}, 16'h0008);
        wr(4'h8, 16'h0000);
        repeat (2) @(posedge clock);
        #1;
        chk("output closed", loopOutputOpen, 1'b0);
        chk("analog disable", loopAnalogEnable, 1'b0);
    endtask
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fails++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        chk("reset pads", {crystalDrive, oscInExtClock, oscOutPadFree}, 3'h3);
        for (int a = 0; a < 16; a += 2)
            rd(a[3:0], 16'h0000, 16'hFFFF);
        $display("reset values done");
        for (int i = 0; i < 48; i++)
        begin
            d = 16'($random(seed));
            @(posedge clock);
            periphRequest <= d[15];
            standbySleep <= d[14];
            wr(4'h0, d);
            repeat (2) @(posedge clock);
            #1;
            chk("osc run", oscRun, d[1] && (!d[14] || d[6]) && (!d[7] || d[15]));
            chk("pads", {crystalDrive, oscInExtClock, oscOutPadFree}, {d[2], !d[2], !d[2]});
            rd(4'h0, d & ocp_pkg::OSC_CTRL_MASK, 16'hFFFF);
            d = 16'($random(seed));
            wr(4'h4, d);
            @(posedge clock);
            #1;
            chk("loop cfg", loopCfg, {d[5:4] == 2'h3 ? 2'h0 : d[5:4], d[2], d[1:0] == 2'h1});
            wr(4'h6, 16'hFFFF);
            rd(4'h6, 16'h0000, 16'hFFFF);
        end
        standbySleep <= 1'b0;
        $display("oscillator and config done");
        for (int c = 0; c < 8; c++)
        begin
            wr(4'h4, {5'h00, c[2:0], 8'h00});
            wr(4'h8, 16'h0002);
            n = 0;
            while (lockTimeout !== 1'b1 && n < 150)
            begin
                @(posedge clock);
                #1;
                n++;
            end
            chk("timeout fired", n < 150, c >= 4);
            if (c >= 4)
                chk("timeout time", n >= (c + 4) * MS && n <= (c + 4) * MS + 4, 1'b1);
            wr(4'h8, 16'h0000);
            wr(4'hC, 16'h0010);
            rd(4'hC, 16'h0000, 16'h0010);
        end
        $display("lock time-out done");
        lp(16'h0000, 1'b0, 12, 1'b0);
        lp(16'h0000, 1'b1, 12, 1'b1);
        lp(16'h0008, 1'b0, 12, 1'b1);
        lp(16'h1000, 1'b0, 4, 1'b1);
        $display("output gating done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
